// ==== hdl/hbg_gate_sequencer.sv ====
// Contract
// - After startup, switch at fixed frequency from internal oscillator or sync input.
// - External sync is divided by six to give the switching frequency.
// - Constant frequency: high gate on at positive half start, for regulated on-time.
// - After high gate off, low gate on while body diode conducts.
// - Zero crossing before clock fall: low off, both off until the fall.
// - On the clock fall, low gate on for the negative half cycle.
// - Clock fall before zero crossing: low gate stays on continuously.
// - Negative half: low off at interval end, then high on, new cycle.
// - Startup runs resonant with sync and phase shift disabled.
// - Resonant: low stays on through zero, off when current turns positive or at interval end, then high.
// - Change from resonant to constant frequency once lamp current regulates.
// - High on-time ends when the internal ramp crosses the compensation level.
// - Rectified lamp current against reference charges or discharges compensation.
// - Overvoltage sense above threshold enables fast compensation discharge until below.
// - A fault registers only after its condition persists a minimum time.
// - After enable, precharge voltage sense to threshold, then let it decay.
// - Switch-voltage sense limits current each cycle and detects zero crossings.
// - Sync and phase logic let up to five devices chain without overlap.
`timescale 1ns/10ps
`include "hbg_cfg.svh"

module hbg_gate_sequencer
	import hbg_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic       cur_positive,
	input  wire logic       current_limit,
	input  wire logic       overvolt_detect,
	input  wire logic       lamp_current_sense,
	input  wire logic       sync_in,
	input  wire logic [2:0] chain_slot,
	output logic            high_gate_drive,
	output logic            low_gate_drive,
	output logic            comp_charge,
	output logic            comp_discharge,
	output logic            ov_discharge,
	output logic            vfb_precharge,
	output logic            const_freq_mode,
	output logic            fault_ov,
	output logic            fault_ocp,
	output logic            chain_sync_out,
	output logic [9:0]      comp_level
);

	logic [`HBG_NUM_PINS-1:0] pin_raw;
	logic [`HBG_NUM_PINS-1:0] pin_s1_reg;
	logic [`HBG_NUM_PINS-1:0] pin_s2_reg;
	logic [`HBG_NUM_PINS-1:0] pin_s3_reg;
	logic [`HBG_NUM_PINS-1:0] pin_lvl_reg;
	logic [`HBG_NUM_QUAL-1:0] qual_raw;
	logic [`HBG_NUM_QUAL-1:0] qual_lvl;
	hbg_state_t               state_reg;
	hbg_state_t               state_next;
	logic [9:0]               osc_cnt_reg;
	logic [9:0]               slot_offset;
	logic [9:0]               ramp_reg;
	logic [9:0]               low_cnt_reg;
	logic [3:0]               dead_cnt_reg;
	logic [3:0]               tick_cnt_reg;
	logic [9:0]               pre_cnt_reg;
	logic                     s_rise;
	logic                     s_fall;
	logic                     sync_ok;
	logic                     osc_rise;
	logic                     osc_fall;
	logic                     cf_rise;
	logic                     cf_fall;
	logic                     rise_pend_reg;
	logic                     fall_pend_reg;
	logic                     dead_done;
	logic                     ontime_end;
	logic                     cur_pos;
	logic                     lamp_low;
	logic                     ilim_q;
	logic                     ov_q;
	logic                     reg_q;
	logic                     to_high;
	logic                     to_low_neg;

	assign pin_raw = {chain_slot, sync_in, lamp_current_sense, overvolt_detect,
	                  current_limit, cur_positive};

	// Three-stage pin sampling; a change counts when stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < `HBG_NUM_PINS; gi++) begin : g_pin
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					pin_s1_reg[gi]  <= 1'b0;
					pin_s2_reg[gi]  <= 1'b0;
					pin_s3_reg[gi]  <= 1'b0;
					pin_lvl_reg[gi] <= 1'b0;
				end else begin
					pin_s1_reg[gi] <= pin_raw[gi];
					pin_s2_reg[gi] <= pin_s1_reg[gi];
					pin_s3_reg[gi] <= pin_s2_reg[gi];
					if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
						pin_lvl_reg[gi] <= pin_s3_reg[gi];
					end
				end
			end
		end
	endgenerate

	assign cur_pos  = pin_lvl_reg[`HBG_P_CURPOS];
	assign lamp_low = pin_lvl_reg[`HBG_P_LAMPLOW];

	// Qualifiers: current limit, overvoltage, lamp-current regulation
	assign qual_raw[`HBG_Q_ILIM] = pin_lvl_reg[`HBG_P_ILIM];
	assign qual_raw[`HBG_Q_OV]   = pin_lvl_reg[`HBG_P_OV];
	assign qual_raw[`HBG_Q_REG]  = !lamp_low;

	generate
		for (gi = 0; gi < `HBG_NUM_QUAL; gi++) begin : g_qual
			hbg_persist #(
				.QUAL ((gi == `HBG_Q_REG) ? `HBG_REG_QUAL : `HBG_QUAL_CYC)
			) u_persist (
				.sys_clk   (sys_clk),
				.srst      (srst),
				.raw       (qual_raw[gi]),
				.qualified (qual_lvl[gi])
			);
		end
	endgenerate

	assign ilim_q = qual_lvl[`HBG_Q_ILIM];
	assign ov_q   = qual_lvl[`HBG_Q_OV];
	assign reg_q  = qual_lvl[`HBG_Q_REG];

	// External sync divider
	hbg_sync_div u_sync_div (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.sync_lvl (pin_lvl_reg[`HBG_P_SYNC]),
		.sw_rise  (s_rise),
		.sw_fall  (s_fall),
		.sync_ok  (sync_ok)
	);

	// Chain slot offset, clamped to the last of five slots
	always_comb begin
		if (pin_lvl_reg[`HBG_P_SLOT +: 3] > 3'(`HBG_CHAIN_MAX)) begin
			slot_offset = 10'(`HBG_CHAIN_MAX * `HBG_SLOT_STEP);
		end else begin
			slot_offset = 10'(pin_lvl_reg[`HBG_P_SLOT +: 3] * `HBG_SLOT_STEP);
		end
	end

	// Internal oscillator; phase set by chain slot at the mode change
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			osc_cnt_reg <= 10'h000;
		end else if (!const_freq_mode && reg_q && to_high) begin
			osc_cnt_reg <= slot_offset;
		end else if (osc_cnt_reg == 10'(`HBG_OSC_LAST)) begin
			osc_cnt_reg <= 10'h000;
		end else begin
			osc_cnt_reg <= osc_cnt_reg + 10'h001;
		end
	end

	assign osc_rise = (osc_cnt_reg == 10'h000);
	assign osc_fall = (osc_cnt_reg == 10'(`HBG_OSC_HALF));

	// Clock source: sync when present, else internal; unused in resonant mode
	assign cf_rise = const_freq_mode && (sync_ok ? s_rise : osc_rise);
	assign cf_fall = const_freq_mode && (sync_ok ? s_fall : osc_fall);

	// Pending clock edges so none is lost during dead time; set wins
	always_ff @(posedge sys_clk) begin
		if (srst || !const_freq_mode) begin
			rise_pend_reg <= 1'b0;
			fall_pend_reg <= 1'b0;
		end else begin
			rise_pend_reg <= cf_rise || (rise_pend_reg && !to_high);
			fall_pend_reg <= cf_fall || (fall_pend_reg && !to_low_neg);
		end
	end

	// One-way switch to constant frequency at a cycle boundary
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			const_freq_mode <= 1'b0;
		end else if (reg_q && to_high) begin
			const_freq_mode <= 1'b1;
		end
	end

	// Precharge of the voltage sense right after enable
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pre_cnt_reg   <= 10'h000;
			vfb_precharge <= 1'b1;
		end else begin
			if (pre_cnt_reg != 10'(`HBG_PRECHARGE_CYC)) begin
				pre_cnt_reg <= pre_cnt_reg + 10'h001;
			end
			vfb_precharge <= (pre_cnt_reg < 10'(`HBG_PRECHARGE_CYC - 1));
		end
	end

	// Compensation integrator, stepped every tick
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tick_cnt_reg <= 4'h0;
			comp_level   <= 10'h000;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 4'h1;
			if (tick_cnt_reg == 4'(`HBG_COMP_TICK - 1)) begin
				if (ov_q) begin
					comp_level <= (comp_level > 10'(`HBG_COMP_OV_DN)) ?
					              comp_level - 10'(`HBG_COMP_OV_DN) : 10'h000;
				end else if (lamp_low) begin
					comp_level <= (comp_level < 10'(`HBG_COMP_MAX - `HBG_COMP_UP)) ?
					              comp_level + 10'(`HBG_COMP_UP) : 10'(`HBG_COMP_MAX);
				end else begin
					comp_level <= (comp_level > 10'(`HBG_COMP_DN)) ?
					              comp_level - 10'(`HBG_COMP_DN) : 10'h000;
				end
			end
		end
	end

	// Error-current and discharge indicators
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			comp_charge    <= 1'b0;
			comp_discharge <= 1'b0;
			ov_discharge   <= 1'b0;
			fault_ov       <= 1'b0;
			fault_ocp      <= 1'b0;
		end else begin
			comp_charge    <= lamp_low && !ov_q;
			comp_discharge <= !lamp_low && !ov_q;
			ov_discharge   <= ov_q;
			fault_ov       <= ov_q;
			fault_ocp      <= ilim_q;
		end
	end

	// On-time ramp, restarted with each high phase
	always_ff @(posedge sys_clk) begin
		if (srst || state_reg != HBG_ST_HIGH) begin
			ramp_reg <= 10'h000;
		end else if (ramp_reg != 10'(`HBG_COMP_MAX)) begin
			ramp_reg <= ramp_reg + 10'h001;
		end
	end

	assign ontime_end = (ramp_reg >= comp_level);

	// Dead time and low-interval counters
	always_ff @(posedge sys_clk) begin
		if (srst || state_next != state_reg) begin
			dead_cnt_reg <= 4'h0;
			low_cnt_reg  <= 10'h000;
		end else begin
			if (!dead_done) begin
				dead_cnt_reg <= dead_cnt_reg + 4'h1;
			end
			if (low_cnt_reg != 10'(`HBG_OSC_LAST)) begin
				low_cnt_reg <= low_cnt_reg + 10'h001;
			end
		end
	end

	assign dead_done  = (dead_cnt_reg == 4'(`HBG_DEAD_CYC - 1));
	assign to_high    = (state_reg == HBG_ST_DEAD_LH) && dead_done;
	assign to_low_neg = (state_next == HBG_ST_LOW_NEG) && (state_reg != HBG_ST_LOW_NEG);

	// Gate sequencing
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			HBG_ST_IDLE: begin
				if (!vfb_precharge) begin
					state_next = HBG_ST_DEAD_LH;
				end
			end
			HBG_ST_HIGH: begin
				if (ontime_end || ilim_q || fall_pend_reg) begin
					state_next = HBG_ST_DEAD_HL;
				end
			end
			HBG_ST_DEAD_HL: begin
				if (dead_done) begin
					state_next = HBG_ST_LOW_POS;
				end
			end
			HBG_ST_LOW_POS: begin
				if (!const_freq_mode) begin
					if (!cur_pos) begin
						state_next = HBG_ST_LOW_NEG;
					end
				end else if (fall_pend_reg) begin
					state_next = HBG_ST_LOW_NEG;
				end else if (!cur_pos) begin
					state_next = HBG_ST_WAIT_FALL;
				end
			end
			HBG_ST_WAIT_FALL: begin
				if (fall_pend_reg) begin
					state_next = HBG_ST_LOW_NEG;
				end
			end
			HBG_ST_LOW_NEG: begin
				if (ilim_q) begin
					state_next = HBG_ST_DEAD_LH;
				end else if (const_freq_mode ? rise_pend_reg :
				             (cur_pos || low_cnt_reg == 10'(`HBG_OSC_LAST))) begin
					state_next = HBG_ST_DEAD_LH;
				end
			end
			HBG_ST_DEAD_LH: begin
				if (dead_done) begin
					state_next = HBG_ST_HIGH;
				end
			end
			default: begin
				state_next = HBG_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_reg <= HBG_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Gate outputs decoded from the next state: high from one state, low from both low states
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			high_gate_drive <= 1'b0;
			low_gate_drive  <= 1'b0;
			chain_sync_out  <= 1'b0;
		end else begin
			high_gate_drive <= (state_next == HBG_ST_HIGH);
			low_gate_drive  <= (state_next == HBG_ST_LOW_POS) ||
			                   (state_next == HBG_ST_LOW_NEG);
			chain_sync_out  <= cf_rise;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	sequence s_dead_gap;
		!high_gate_drive && !low_gate_drive;
	endsequence

	property p_no_overlap;
		!(high_gate_drive && low_gate_drive);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("both gates on");

	property p_low_after_high;
		$fell(high_gate_drive) && state_reg == HBG_ST_DEAD_HL
			|-> s_dead_gap ##[4:6] low_gate_drive;
	endproperty
	a_low_after_high: assert property (p_low_after_high) else $error("low gate late");

	property p_wait_off;
		state_reg == HBG_ST_WAIT_FALL |-> s_dead_gap;
	endproperty
	a_wait_off: assert property (p_wait_off) else $error("gate on while waiting");

	property p_fall_low_on;
		state_reg == HBG_ST_WAIT_FALL && fall_pend_reg |=> low_gate_drive;
	endproperty
	a_fall_low_on: assert property (p_fall_low_on) else $error("low not on at fall");

	property p_fall_keeps_low;
		const_freq_mode && state_reg == HBG_ST_LOW_POS && fall_pend_reg && !ilim_q
			|=> low_gate_drive [*2];
	endproperty
	a_fall_keeps_low: assert property (p_fall_keeps_low) else $error("low dropped");

	property p_neg_end;
		const_freq_mode && state_reg == HBG_ST_LOW_NEG && rise_pend_reg
			|=> !low_gate_drive ##[4:6] high_gate_drive;
	endproperty
	a_neg_end: assert property (p_neg_end) else $error("no new cycle");

	property p_res_nosync;
		!const_freq_mode |-> !chain_sync_out && !rise_pend_reg;
	endproperty
	a_res_nosync: assert property (p_res_nosync) else $error("sync in resonant");

	property p_mode_change;
		$rose(const_freq_mode) |-> $past(reg_q);
	endproperty
	a_mode_change: assert property (p_mode_change) else $error("early mode change");

	property p_ontime;
		state_reg == HBG_ST_HIGH && ontime_end |=> !high_gate_drive;
	endproperty
	a_ontime: assert property (p_ontime) else $error("on-time overrun");

	property p_ov_disch;
		ov_q |=> ov_discharge && !comp_charge;
	endproperty
	a_ov_disch: assert property (p_ov_disch) else $error("no ov discharge");

	property p_precharge;
		$past(srst) |-> vfb_precharge;
	endproperty
	a_precharge: assert property (p_precharge) else $error("no precharge");

endmodule

// ==== hdl/hbg_cfg.svh ====
`ifndef HBG_CFG_SVH
`define HBG_CFG_SVH

// Clock rate of sys_clk
`define HBG_CLK_HZ       25000000
`define HBG_CLK_MHZ      (`HBG_CLK_HZ / 1000000)

// Internal switching oscillator
`define HBG_OSC_HZ       54000
`define HBG_OSC_PERIOD   (`HBG_CLK_HZ / `HBG_OSC_HZ)
`define HBG_OSC_LAST     (`HBG_OSC_PERIOD - 1)
`define HBG_OSC_HALF     (`HBG_OSC_PERIOD / 2)

// Phase chaining: five slots per period
`define HBG_CHAIN_SLOTS  5
`define HBG_CHAIN_MAX    (`HBG_CHAIN_SLOTS - 1)
`define HBG_SLOT_STEP    (`HBG_OSC_PERIOD / `HBG_CHAIN_SLOTS)

// External sync divider
`define HBG_SYNC_DIV     6
`define HBG_SYNC_LAST    (`HBG_SYNC_DIV - 1)
`define HBG_SYNC_MID     (`HBG_SYNC_DIV / 2 - 1)
`define HBG_SYNC_LOST    300

// Dead time between gates, least time rounded up
`define HBG_DEAD_NS      200
`define HBG_DEAD_CYC     ((`HBG_DEAD_NS * `HBG_CLK_MHZ + 999) / 1000)

// Sense-input precharge after enable
`define HBG_PRECHARGE_US 20
`define HBG_PRECHARGE_CYC (`HBG_PRECHARGE_US * `HBG_CLK_MHZ)

// Fault and regulation qualification
`define HBG_QUAL_CYC     4
`define HBG_REG_QUAL     64
`define HBG_NUM_QUAL     3
`define HBG_Q_ILIM       0
`define HBG_Q_OV         1
`define HBG_Q_REG        2

// Compensation integrator
`define HBG_COMP_TICK    16
`define HBG_COMP_MAX     1023
`define HBG_COMP_UP      1
`define HBG_COMP_DN      1
`define HBG_COMP_OV_DN   4

// Pin sampler lanes
`define HBG_NUM_PINS     8
`define HBG_P_CURPOS     0
`define HBG_P_ILIM       1
`define HBG_P_OV         2
`define HBG_P_LAMPLOW    3
`define HBG_P_SYNC       4
`define HBG_P_SLOT       5

`endif

// ==== hdl/hbg_pkg.sv ====
package hbg_pkg;

	typedef enum logic [2:0] {
		HBG_ST_IDLE,
		HBG_ST_HIGH,
		HBG_ST_DEAD_HL,
		HBG_ST_LOW_POS,
		HBG_ST_WAIT_FALL,
		HBG_ST_LOW_NEG,
		HBG_ST_DEAD_LH
	} hbg_state_t;

endpackage

// ==== hdl/hbg_persist.sv ====
`timescale 1ns/10ps
`include "hbg_cfg.svh"

module hbg_persist #(
	parameter int unsigned QUAL = `HBG_QUAL_CYC
) (
	input  wire logic sys_clk,
	input  wire logic srst,
	input  wire logic raw,
	output logic      qualified
);

	logic [7:0] cnt_reg;

	// Count how long the condition has held
	always_ff @(posedge sys_clk) begin
		if (srst || !raw) begin
			cnt_reg <= 8'h00;
		end else if (cnt_reg != 8'(QUAL)) begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	// Qualified once held long enough, dropped at once
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			qualified <= 1'b0;
		end else begin
			qualified <= raw && (cnt_reg >= 8'(QUAL - 1));
		end
	end

	property p_persist;
		@(posedge sys_clk) disable iff (srst)
		$rose(qualified) |-> $past(raw) && ($past(cnt_reg) == 8'(QUAL - 1));
	endproperty
	a_persist: assert property (p_persist) else $error("fault qualified too early");

endmodule

// ==== hdl/hbg_sync_div.sv ====
`timescale 1ns/10ps
`include "hbg_cfg.svh"

module hbg_sync_div (
	input  wire logic sys_clk,
	input  wire logic srst,
	input  wire logic sync_lvl,
	output logic      sw_rise,
	output logic      sw_fall,
	output logic      sync_ok
);

	logic       prev_reg;
	logic [2:0] edge_cnt_reg;
	logic [8:0] lost_cnt_reg;
	logic       sync_edge;
	logic [3:0] chk_cnt_reg;

	assign sync_edge = sync_lvl && !prev_reg;

	// Rising-edge detect on the filtered sync level
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= sync_lvl;
		end
	end

	// Divide by six: start at edge six, falling point at edge three
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			edge_cnt_reg <= 3'h0;
			sw_rise      <= 1'b0;
			sw_fall      <= 1'b0;
		end else begin
			sw_rise <= sync_edge && (edge_cnt_reg == 3'(`HBG_SYNC_LAST));
			sw_fall <= sync_edge && (edge_cnt_reg == 3'(`HBG_SYNC_MID));
			if (sync_edge) begin
				edge_cnt_reg <= (edge_cnt_reg == 3'(`HBG_SYNC_LAST)) ? 3'h0
				                : edge_cnt_reg + 3'h1;
			end
		end
	end

	// Sync present while edges keep coming; else fall back
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			lost_cnt_reg <= 9'(`HBG_SYNC_LOST);
			sync_ok      <= 1'b0;
		end else begin
			if (sync_edge) begin
				lost_cnt_reg <= 9'h000;
			end else if (lost_cnt_reg != 9'(`HBG_SYNC_LOST)) begin
				lost_cnt_reg <= lost_cnt_reg + 9'h001;
			end
			sync_ok <= sync_edge || (lost_cnt_reg < 9'(`HBG_SYNC_LOST - 1));
		end
	end

	// Edges seen since the last start pulse, for checking only
	always_ff @(posedge sys_clk) begin
		if (srst || sw_rise) begin
			chk_cnt_reg <= sync_edge ? 4'h1 : 4'h0;
		end else if (sync_edge && chk_cnt_reg != 4'hf) begin
			chk_cnt_reg <= chk_cnt_reg + 4'h1;
		end
	end

	property p_div_six;
		@(posedge sys_clk) disable iff (srst)
		sw_rise && $past(sw_rise, 1) == 1'b0 && chk_cnt_reg != 4'h0
			|-> chk_cnt_reg == 4'(`HBG_SYNC_DIV);
	endproperty
	a_div_six: assert property (p_div_six) else $error("sync not divided by six");

endmodule

// ==== tb/hbg_tank_model.sv ====
`timescale 1ns/10ps
module hbg_tank_model (
	input  wire logic       sys_clk,
	input  wire logic       high_gate_drive,
	input  wire logic [9:0] cross_dly,
	input  wire logic [9:0] neg_len,
	output logic            cur_positive
);
	logic [10:0] off_cnt_reg = 11'h7ff;

	// Cycles since the high-side switch last turned off
	always @(posedge sys_clk) begin
		if (high_gate_drive)
			off_cnt_reg <= 11'h000;
		else if (off_cnt_reg != 11'h7ff)
			off_cnt_reg <= off_cnt_reg + 11'h001;
	end

	// Current crosses zero after cross_dly, swings back positive after neg_len
	assign cur_positive = !(off_cnt_reg >= {1'b0, cross_dly} &&
		off_cnt_reg < {1'b0, cross_dly} + {1'b0, neg_len});
endmodule

// ==== tb/hbg_gate_sequencer_tb_top.sv ====
`timescale 1ns/10ps
module hbg_gate_sequencer_tb_top;
	logic       sys_clk = 1'b0;
	logic       srst = 1'b1;
	logic       current_limit = 1'b0;
	logic       overvolt_detect = 1'b0;
	logic       lamp_current_sense = 1'b1;
	logic       sync_in = 1'b0;
	logic       sync_on = 1'b0;
	logic [2:0] chain_slot = 3'h2;
	logic [9:0] cross_dly = 10'h014;
	logic [9:0] neg_len = 10'h03c;
	logic       cur_positive, high_gate_drive, low_gate_drive, comp_charge;
	logic       comp_discharge, ov_discharge, vfb_precharge, const_freq_mode;
	logic       fault_ov, fault_ocp, chain_sync_out;
	logic [9:0] comp_level, lvl;
	int         mismatches = 0;
	int         tests_run = 0;
	int         cyc = 0;
	int         sync_cnt = 0;
	int         len, lows, wid, gap, syncs, w1;

	hbg_gate_sequencer hbg_gate_sequencer_inst (
		.sys_clk(sys_clk), .srst(srst), .cur_positive(cur_positive),
		.current_limit(current_limit), .overvolt_detect(overvolt_detect),
		.lamp_current_sense(lamp_current_sense), .sync_in(sync_in),
		.chain_slot(chain_slot), .high_gate_drive(high_gate_drive),
		.low_gate_drive(low_gate_drive), .comp_charge(comp_charge),
		.comp_discharge(comp_discharge), .ov_discharge(ov_discharge),
		.vfb_precharge(vfb_precharge), .const_freq_mode(const_freq_mode),
		.fault_ov(fault_ov), .fault_ocp(fault_ocp), .chain_sync_out(chain_sync_out),
		.comp_level(comp_level)
	);

	hbg_tank_model hbg_tank_model_inst (
		.sys_clk(sys_clk), .high_gate_drive(high_gate_drive), .cross_dly(cross_dly),
		.neg_len(neg_len), .cur_positive(cur_positive)
	);

	// 25 MHz clock
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end

	// External sync source, 80-cycle period (312.5 kHz), idles low when off
	always @(posedge sys_clk) begin
		#1;
		sync_cnt = (sync_cnt == 79) ? 0 : sync_cnt + 1;
		sync_in = sync_on && (sync_cnt < 40);
	end

	// Cycle count, run ceiling and gate overlap watch
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (high_gate_drive === 1'b1 && low_gate_drive === 1'b1) begin
			mismatches++;
			$display("wrong value at %0t: both gates on", $time);
		end
		if (cyc == 40000) begin
			mismatches++;
			$display("wrong value at %0t: run ceiling hit", $time);
			conclude();
		end
	end

	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// Measures one switching period from a high-gate rise to the next
	task automatic period();
		int   t0;
		logic ph;
		logic pl;
		t0 = 0;
		ph = 1'b1;
		for (int i = 0; i < 2000 && t0 == 0; i++) begin
			cycles(1);
			if (high_gate_drive === 1'b1 && !ph)
				t0 = cyc;
			ph = high_gate_drive;
		end
		lows = 0;
		wid = 1;
		gap = 0;
		syncs = 0;
		pl = low_gate_drive;
		for (int i = 0; i < 2000; i++) begin
			cycles(1);
			if (high_gate_drive === 1'b1 && !ph)
				break;
			lows += (low_gate_drive === 1'b1 && !pl);
			wid += (high_gate_drive === 1'b1);
			gap += (!cur_positive && high_gate_drive === 1'b0 && low_gate_drive === 1'b0);
			syncs += (chain_sync_out === 1'b1);
			ph = high_gate_drive;
			pl = low_gate_drive;
		end
		len = cyc - t0;
	endtask

	task automatic test_precharge();
		cycles(490);
		chk(vfb_precharge === 1'b1 && high_gate_drive === 1'b0, "precharge short");
		cycles(20);
		chk(vfb_precharge === 1'b0, "precharge stuck");
		$display("test precharge done");
	endtask

	task automatic test_resonant();
		period();
		period();
		chk(lows == 1 && gap == 0, "low gate left zero crossing");
		chk(const_freq_mode === 1'b0, "left resonant early");
		chk(comp_charge === 1'b1, "no comp charge");
		$display("test resonant done");
	endtask

	task automatic test_faults();
		overvolt_detect = 1'b1;
		cycles(5);
		chk(fault_ov === 1'b0, "overvoltage not qualified");
		cycles(10);
		chk(fault_ov === 1'b1 && ov_discharge === 1'b1, "no ov discharge");
		lvl = comp_level;
		cycles(64);
		chk(comp_level < lvl, "comp not falling");
		overvolt_detect = 1'b0;
		cycles(10);
		chk(ov_discharge === 1'b0 && fault_ov === 1'b0, "ov discharge stuck");
		current_limit = 1'b1;
		cycles(5);
		chk(fault_ocp === 1'b0, "limit not qualified");
		cycles(10);
		chk(fault_ocp === 1'b1, "no limit fault");
		current_limit = 1'b0;
		cycles(10);
		$display("test faults done");
	endtask

	task automatic test_mode_switch();
		lamp_current_sense = 1'b0;
		for (int i = 0; i < 3000 && const_freq_mode !== 1'b1; i++)
			cycles(1);
		chk(const_freq_mode === 1'b1, "no constant frequency");
		cycles(20);
		chk(comp_discharge === 1'b1, "no comp discharge");
		lamp_current_sense = 1'b1;
		cycles(2400);
		lamp_current_sense = 1'b0;
		$display("test mode switch done");
	endtask

	task automatic test_const_freq();
		period();
		period();
		chk(len == 462, "internal period");
		chk(syncs == 1, "chain pulse count");
		chk(lows == 2 && gap > 0, "zero before fall");
		w1 = wid;
		period();
		period();
		chk(wid < w1, "on-time ignores comp");
		cross_dly = 10'h12c;
		period();
		period();
		chk(lows == 1 && gap == 0, "fall before zero");
		$display("test constant frequency done");
	endtask

	task automatic test_sync();
		sync_on = 1'b1;
		repeat (5) period();
		chk(len == 480, "sync divide by six");
		sync_on = 1'b0;
		repeat (3) period();
		chk(len == 462, "no fallback to oscillator");
		$display("test sync done");
	endtask

	task automatic conclude();
		$display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Main sequence
	initial begin
		cycles(5);
		chk(vfb_precharge === 1'b1 && low_gate_drive === 1'b0, "reset state");
		srst = 1'b0;
		test_precharge();
		test_resonant();
		test_faults();
		test_mode_switch();
		test_const_freq();
		test_sync();
		conclude();
	end
endmodule
